/* File: verilog/das_pkg.sv */
/*
 * Constants for the drive alarm status words block: bit values of the
 * alarm codes, register offsets on the plain register port, reset values.
 * Assumes a single 100 MHz clock and one 16-bit register data path.
 */
package das_pkg;
    localparam logic [15:0] ALM_OVERSPEED = 16'h0001;
    localparam logic [15:0] ALM_RSVD_A = 16'h0002;
    localparam logic [15:0] ALM_RSVD_B = 16'h0004;
    localparam logic [15:0] ALM_FIN_TEMP = 16'h0008;
    localparam logic [15:0] ALM_MOTOR_TEMP = 16'h0010;
    localparam logic [15:0] ALM_OVER_VOLTS = 16'h0020;
    localparam logic [15:0] ALM_UNDER_VOLTS = 16'h0040;
    localparam logic [15:0] ALM_SPEED_FB = 16'h0080;
    localparam logic [15:0] ALM_POWER_LOSS = 16'h0100;
    localparam logic [15:0] ALM_STACK_TRIP = 16'h0200;
    localparam logic [15:0] ALM_AUTOTUNE = 16'h0400;
    localparam logic [15:0] ALM_SERIAL_RX = 16'h0800;
    localparam logic [15:0] ALM_STALL = 16'h1000;
    localparam logic [15:0] ALM_OVER_CURRENT = 16'h2000;
    localparam logic [15:0] ALM_EXTERNAL = 16'h4000;
    localparam logic [15:0] ALM_OTHER = 16'h8000;
    localparam logic [15:0] ALM_RESERVED = 16'h0006;
    // Alarms that may be inhibited; the stack trip cannot be.
    localparam logic [15:0] ALM_INHIBITABLE = 16'hFDF9;

    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_EARLIEST = 4'h0;
    localparam logic [3:0] OFS_LATCHED = 4'h1;
    localparam logic [3:0] OFS_LIVE = 4'h2;
    localparam logic [3:0] OFS_INHIBIT = 4'h3;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h5;
    localparam logic [3:0] OFS_IO_STATE = 4'h6;

    localparam logic [15:0] INHIBIT_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // Interrupt status bit positions.
    localparam int IRQ_FIRST = 0;
    localparam int IRQ_TRIP = 1;
    localparam int IRQ_NEW_ALARM = 2;

    // Input/output state word bit positions.
    localparam int IO_ENABLE = 0;
    localparam int IO_HOLD = 1;
    localparam int IO_PRESET_LO = 2;
    localparam int IO_ZERO = 5;
    localparam int IO_HEALTH = 6;
    localparam int IO_READY = 7;
    localparam int IO_LED = 8;

    typedef enum logic [1:0] {
        DAS_IDLE = 2'b00,
        DAS_RUN = 2'b01,
        DAS_TRIPPED = 2'b11
    } das_state_t;
endpackage : das_pkg

/* File: verilog/das_top.sv */
/*
 * Drive alarm status words: live, earliest and latched alarm codes, the
 * default digital line functions, and a small interrupt block.
 * Assumes alarm conditions and drive inputs arrive asynchronously and are
 * synchronised here; the register master follows the plain port protocol.
 */
// Summary of operation
// - Three 16-bit alarm words, each bit with its own meaning.
// - Live word shows every active alarm at once, many bits together.
// - Earliest and latched words hold at most one set bit.
// - Overspeed 0x0001, fin temperature 0x0008, motor temperature 0x0010.
// - Speed feedback loss 0x0080; bits 0x0002 and 0x0004 never set.
// - Power loss stop 0x0100, undervoltage 0x0040.
// - Stack trip 0x0200, overcurrent 0x2000, overvoltage 0x0020.
// - Serial slave receive failure 0x0800, autotune error 0x0400.
// - Stall 0x1000, external trip 0x4000, other alarms 0x8000.
// - Software inhibit flags suppress chosen alarms; not all inhibitable.
// - Digital output two shows health and is on while start is low.
// - Panel health lamp stays off after a fault until restart.
// - Setpoint taken before ramp-to-zero, which acts only in stop states.
// - Enable input ON enables the drive, OFF disables it.
// - Digital input one ON holds the ramp output.
// - Digital inputs two to four form preset select lines one to three.
// - Output one is zero speed, output three is ready.
// - Stall when current over threshold at zero speed and demand nonzero.
module das_top
    import das_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESETN,
    // Register port.
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    output logic IRQ,
    // Alarm conditions, one per code bit; bits 1 and 2 are ignored.
    input wire logic [15:0] ALARM_COND,
    // Stall detection terms.
    input wire logic OVER_STALL_CURRENT,
    input wire logic AT_ZERO_SPEED,
    input wire logic AT_ZERO_SETPOINT,
    // Drive terminals.
    input wire logic START_IN,
    input wire logic ENABLE_IN,
    input wire logic DIGITAL_INPUT_ONE,
    input wire logic DIGITAL_INPUT_TWO,
    input wire logic DIGITAL_INPUT_THREE,
    input wire logic DIGITAL_INPUT_FOUR,
    input wire logic DRIVE_READY_IN,
    // Stop states for the ramp-to-zero stage.
    input wire logic NORMAL_STOP,
    input wire logic PROGRAM_STOP,
    input wire logic COAST_STOP,
    // Default function outputs.
    output logic DRIVE_ENABLE,
    output logic RAMP_HOLD,
    output logic [2:0] PRESET_SELECT,
    output logic RAMP_TO_ZERO_ACTIVE,
    output logic DIGITAL_OUTPUT_ONE,
    output logic DIGITAL_OUTPUT_TWO,
    output logic DIGITAL_OUTPUT_THREE,
    output logic HEALTH_LED
);
    logic rst_meta, rst_n;
    logic [15:0] cond_meta, cond_sync;
    logic [11:0] pin_meta, pin_sync;
    logic [15:0] live_reg, earliest_reg, latched_reg, inhibit_reg;
    logic [15:0] live_next, pick;
    logic [2:0] irq_status_reg, irq_mask_reg, irq_set;
    logic start_q, start_rise, stall_now;
    logic led_reg, zero_reg, health_reg, ready_reg;
    logic enable_reg, hold_reg, rtz_reg;
    logic [2:0] preset_reg;
    logic [15:0] rdata_reg;
    das_state_t state_reg, state_next;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Two-stage synchronisers for every asynchronous input.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cond_meta <= WORD_ZERO;
            cond_sync <= WORD_ZERO;
            pin_meta <= 12'h000;
            pin_sync <= 12'h000;
        end else begin
            cond_meta <= ALARM_COND;
            cond_sync <= cond_meta;
            pin_meta <= {COAST_STOP, PROGRAM_STOP, NORMAL_STOP, DRIVE_READY_IN,
                         AT_ZERO_SETPOINT, AT_ZERO_SPEED, OVER_STALL_CURRENT,
                         DIGITAL_INPUT_FOUR, DIGITAL_INPUT_THREE, DIGITAL_INPUT_TWO,
                         DIGITAL_INPUT_ONE, ENABLE_IN};
            pin_sync <= pin_meta;
        end
    end

    logic start_meta, start_sync;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            start_meta <= 1'b0;
            start_sync <= 1'b0;
            start_q <= 1'b0;
        end else begin
            start_meta <= START_IN;
            start_sync <= start_meta;
            start_q <= start_sync;
        end
    end
    assign start_rise = start_sync & ~start_q;

    // Stall needs current over threshold at zero speed with nonzero demand.
    assign stall_now = pin_sync[5] & pin_sync[6] & ~pin_sync[7];

    always_comb begin
        live_next = cond_sync;
        live_next[12] = cond_sync[12] | stall_now;
        live_next = live_next & ~ALM_RESERVED;
        live_next = live_next & ~(inhibit_reg & ALM_INHIBITABLE);
    end

    // Live word follows the conditions as soon as they are seen.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            live_reg <= WORD_ZERO;
        end else begin
            live_reg <= live_next;
        end
    end

    // Lowest set bit of the live conditions picks the single recorded cause.
    assign pick = live_next & (~live_next + 16'h0001);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DAS_IDLE: begin
                if (start_rise) begin
                    state_next = DAS_RUN;
                end
            end
            DAS_RUN: begin
                if (pick != WORD_ZERO) begin
                    state_next = DAS_TRIPPED;
                end
            end
            DAS_TRIPPED: begin
                if (start_rise) begin
                    state_next = DAS_RUN;
                end
            end
            default: begin
                state_next = DAS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= DAS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Earliest alarm: captured once per start, cleared only on restart.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            earliest_reg <= WORD_ZERO;
        end else if (start_rise) begin
            earliest_reg <= WORD_ZERO;
        end else if (state_reg == DAS_RUN && pick != WORD_ZERO) begin
            earliest_reg <= pick;
        end
    end

    // Latched trip store: lowest live alarm on any cycle not tripped (idle or run), one bit only.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            latched_reg <= WORD_ZERO;
        end else if (state_reg != DAS_TRIPPED && pick != WORD_ZERO) begin
            latched_reg <= pick;
        end
    end

    // Panel lamp stays dark after a fault until the drive is restarted.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            led_reg <= 1'b1;
        end else if (start_rise) begin
            led_reg <= 1'b1;
        end else if (pick != WORD_ZERO) begin
            led_reg <= 1'b0;
        end
    end

    // Default functions of the digital lines.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= 1'b0;
            hold_reg <= 1'b0;
            preset_reg <= 3'h0;
            zero_reg <= 1'b0;
            health_reg <= 1'b1;
            ready_reg <= 1'b0;
            rtz_reg <= 1'b0;
        end else begin
            enable_reg <= pin_sync[0];
            hold_reg <= pin_sync[1];
            preset_reg <= pin_sync[4:2];
            zero_reg <= pin_sync[6];
            health_reg <= ~start_sync | (live_next == WORD_ZERO);
            ready_reg <= pin_sync[8];
            rtz_reg <= |pin_sync[11:9];
        end
    end

    assign DRIVE_ENABLE = enable_reg;
    assign RAMP_HOLD = hold_reg;
    assign PRESET_SELECT = preset_reg;
    assign RAMP_TO_ZERO_ACTIVE = rtz_reg;
    assign DIGITAL_OUTPUT_ONE = zero_reg;
    assign DIGITAL_OUTPUT_TWO = health_reg;
    assign DIGITAL_OUTPUT_THREE = ready_reg;
    assign HEALTH_LED = led_reg;

    // Interrupt events: earliest captured, trip latched, any new live bit.
    assign irq_set[IRQ_FIRST] = state_reg == DAS_RUN && pick != WORD_ZERO;
    assign irq_set[IRQ_TRIP] = state_reg != DAS_TRIPPED && pick != WORD_ZERO;
    assign irq_set[IRQ_NEW_ALARM] = (live_next & ~live_reg) != WORD_ZERO;

    // Read of the status clears it, but an event in the same cycle wins.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_reg <= 3'h0;
        end else if (REG_RD && REG_ADDR == OFS_IRQ_STATUS) begin
            irq_status_reg <= irq_set;
        end else begin
            irq_status_reg <= irq_status_reg | irq_set;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_reg <= MASK_RESET[2:0];
            inhibit_reg <= INHIBIT_RESET;
        end else if (REG_WR) begin
            if (REG_ADDR == OFS_IRQ_MASK) begin
                irq_mask_reg <= REG_WDATA[2:0];
            end
            if (REG_ADDR == OFS_INHIBIT) begin
                inhibit_reg <= REG_WDATA;
            end
        end
    end

    assign IRQ = |(irq_status_reg & irq_mask_reg);

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= WORD_ZERO;
        end else if (REG_RD) begin
            case (REG_ADDR)
                OFS_EARLIEST: rdata_reg <= earliest_reg;
                OFS_LATCHED: rdata_reg <= latched_reg;
                OFS_LIVE: rdata_reg <= live_reg;
                OFS_INHIBIT: rdata_reg <= inhibit_reg;
                OFS_IRQ_STATUS: rdata_reg <= {13'h0000, irq_status_reg};
                OFS_IRQ_MASK: rdata_reg <= {13'h0000, irq_mask_reg};
                OFS_IO_STATE: rdata_reg <= {7'h00, led_reg, ready_reg, health_reg,
                                            zero_reg, preset_reg, hold_reg, enable_reg};
                default: rdata_reg <= WORD_ZERO;
            endcase
        end else begin
            rdata_reg <= WORD_ZERO;
        end
    end
    assign REG_RDATA = rdata_reg;

    property p_onehot_earliest;
        @(posedge CLK) disable iff (!rst_n) $onehot0(earliest_reg);
    endproperty
    a_onehot_earliest: assert property (p_onehot_earliest) else $error("earliest >1 bit");

    property p_onehot_latched;
        @(posedge CLK) disable iff (!rst_n) $onehot0(latched_reg);
    endproperty
    a_onehot_latched: assert property (p_onehot_latched) else $error("latched multi-bit");

    property p_reserved;
        @(posedge CLK) disable iff (!rst_n)
            (live_reg & ALM_RESERVED) == WORD_ZERO && (earliest_reg & ALM_RESERVED) == WORD_ZERO;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_live_follow;
        @(posedge CLK) disable iff (!rst_n)
            ##1 live_reg == (($past(cond_sync) & ~ALM_RESERVED
                              & ~$past(inhibit_reg & ALM_INHIBITABLE))
                             | ($past(stall_now && !inhibit_reg[12]) ? ALM_STALL : WORD_ZERO));
    endproperty
    a_live_follow: assert property (p_live_follow) else $error("live word wrong");

    property p_inhibit;
        @(posedge CLK) disable iff (!rst_n)
            inhibit_reg[0] |=> !live_reg[0];
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibited alarm shown");

    sequence s_restart;
        start_rise;
    endsequence
    property p_first_clear;
        @(posedge CLK) disable iff (!rst_n) s_restart |=> earliest_reg == WORD_ZERO && led_reg;
    endproperty
    a_first_clear: assert property (p_first_clear) else $error("restart not cleared");

    property p_first_hold;
        @(posedge CLK) disable iff (!rst_n)
            (earliest_reg != WORD_ZERO && !start_rise) |=> $stable(earliest_reg);
    endproperty
    a_first_hold: assert property (p_first_hold) else $error("earliest changed");

    property p_health_start_low;
        @(posedge CLK) disable iff (!rst_n) !start_sync |=> DIGITAL_OUTPUT_TWO;
    endproperty
    a_health_start_low: assert property (p_health_start_low) else $error("health off");

    property p_led_off;
        @(posedge CLK) disable iff (!rst_n)
            (!led_reg && !start_rise) |=> !led_reg;
    endproperty
    a_led_off: assert property (p_led_off) else $error("lamp relit");

    property p_stall;
        @(posedge CLK) disable iff (!rst_n)
            (stall_now && !inhibit_reg[12]) |=> live_reg[12];
    endproperty
    a_stall: assert property (p_stall) else $error("stall missed");

    property p_rdata_idle;
        @(posedge CLK) disable iff (!rst_n) !REG_RD |=> REG_RDATA == WORD_ZERO;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

    sequence s_new_cause;
        pick != WORD_ZERO && !start_rise;
    endsequence
    property p_lamp_dark;
        @(posedge CLK) disable iff (!rst_n) s_new_cause |=> !HEALTH_LED;
    endproperty
    a_lamp_dark: assert property (p_lamp_dark) else $error("lamp lit after fault");

    property p_first_capture;
        @(posedge CLK) disable iff (!rst_n)
            (state_reg == DAS_RUN && pick != WORD_ZERO && !start_rise)
            |=> earliest_reg == $past(pick);
    endproperty
    a_first_capture: assert property (p_first_capture) else $error("earliest not taken");

    property p_stop_ramp;
        @(posedge CLK) disable iff (!rst_n) (|pin_sync[11:9]) |=> RAMP_TO_ZERO_ACTIVE;
    endproperty
    a_stop_ramp: assert property (p_stop_ramp) else $error("ramp to zero idle");

    property p_pin_follow;
        @(posedge CLK) disable iff (!rst_n)
            ##1 DRIVE_ENABLE == $past(pin_sync[0]) && DIGITAL_OUTPUT_THREE == $past(pin_sync[8]);
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pin copy wrong");
endmodule : das_top

/* File: verification/das_drive_model.sv */
/*
 * Drive-side model: the control firmware and terminal wiring that feed
 * the alarm status block with alarm levels and terminal levels.
 * Assumes the bench calls apply() and that the block samples the levels
 * through its own synchronisers.
 */
module das_drive_model (
    // Clock.
    input wire logic clk,
    // Levels towards the block.
    output logic [15:0] alarm_cond,
    output logic [12:0] terms
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        alarm_cond = 16'h0000;
        terms = 13'h0000;
    end

    // Levels change only just after a rising edge and then hold.
    task automatic apply(input logic [15:0] a, input logic [12:0] t);
        @(posedge clk);
        alarm_cond <= a;
        terms <= t;
    endtask : apply
endmodule : das_drive_model

/* File: verification/drive_alarm_status_words_tb_top.sv */
/*
 * Self-checking bench for the alarm status block: register reads and
 * writes on the plain port, alarm codes, interrupts and terminal functions.
 * Assumes the drive model in its own file and the package constants.
 */
module drive_alarm_status_words_tb_top
    import das_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [12:0] T_START = 13'h0001;
    localparam logic [12:0] T_EN = 13'h0002;
    localparam logic [12:0] T_DI1 = 13'h0004;
    localparam logic [12:0] T_DI2 = 13'h0008;
    localparam logic [12:0] T_DI4 = 13'h0020;
    localparam logic [12:0] T_RDY = 13'h0040;
    localparam logic [12:0] T_NS = 13'h0080;
    localparam logic [12:0] T_OC = 13'h0400;
    localparam logic [12:0] T_ZS = 13'h0800;
    localparam logic [12:0] T_ZSP = 13'h1000;

    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [3:0] REG_ADDR = 4'h0;
    logic [15:0] REG_WDATA = 16'h0000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [15:0] REG_RDATA;
    logic IRQ, DRIVE_ENABLE, RAMP_HOLD, RAMP_TO_ZERO_ACTIVE, HEALTH_LED;
    logic [2:0] PRESET_SELECT;
    logic DIGITAL_OUTPUT_ONE, DIGITAL_OUTPUT_TWO, DIGITAL_OUTPUT_THREE;
    logic [15:0] alarm_cond;
    logic [12:0] terms;
    int n_errors = 0;
    int n_checks = 0;
    logic [15:0] exp_code;
    logic [15:0] exp_rst [0:6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                   16'h0000, 16'h0000, 16'h0140};

    initial begin
        forever #5 CLK = ~CLK;
    end

    das_drive_model m (.clk(CLK), .alarm_cond(alarm_cond), .terms(terms));

    das_top dut (
        .CLK(CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ),
        .ALARM_COND(alarm_cond), .OVER_STALL_CURRENT(terms[10]),
        .AT_ZERO_SPEED(terms[11]), .AT_ZERO_SETPOINT(terms[12]),
        .START_IN(terms[0]), .ENABLE_IN(terms[1]), .DIGITAL_INPUT_ONE(terms[2]),
        .DIGITAL_INPUT_TWO(terms[3]), .DIGITAL_INPUT_THREE(terms[4]),
        .DIGITAL_INPUT_FOUR(terms[5]), .DRIVE_READY_IN(terms[6]),
        .NORMAL_STOP(terms[7]), .PROGRAM_STOP(terms[8]), .COAST_STOP(terms[9]),
        .DRIVE_ENABLE(DRIVE_ENABLE), .RAMP_HOLD(RAMP_HOLD),
        .PRESET_SELECT(PRESET_SELECT), .RAMP_TO_ZERO_ACTIVE(RAMP_TO_ZERO_ACTIVE),
        .DIGITAL_OUTPUT_ONE(DIGITAL_OUTPUT_ONE), .DIGITAL_OUTPUT_TWO(DIGITAL_OUTPUT_TWO),
        .DIGITAL_OUTPUT_THREE(DIGITAL_OUTPUT_THREE), .HEALTH_LED(HEALTH_LED)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1;
        check(REG_RDATA, e);
    endtask : rd

    // Pin to live word is three edges; two more give margin.
    task automatic settle();
        repeat (5) @(posedge CLK);
        #1;
    endtask : settle

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    initial begin
        #500000;
        n_errors++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (3) @(posedge CLK);
        #1;
        check({15'h0000, DIGITAL_OUTPUT_TWO}, 16'h0001);
        check({15'h0000, HEALTH_LED}, 16'h0001);
        for (int a = 0; a < 7; a++) begin
            rd(a[3:0], exp_rst[a]);
        end
        rd(4'hF, WORD_ZERO);
        wr(OFS_INHIBIT, 16'h1234);
        rd(OFS_INHIBIT, 16'h1234);
        wr(OFS_LIVE, 16'hFFFF);
        rd(OFS_LIVE, WORD_ZERO);
        wr(OFS_INHIBIT, INHIBIT_RESET);
        $display("Test reset and access done");

        m.apply(16'h0000, T_START);
        settle();
        m.apply(ALM_FIN_TEMP | ALM_OVER_VOLTS, T_START);
        settle();
        rd(OFS_LIVE, 16'h0028);
        rd(OFS_EARLIEST, ALM_FIN_TEMP);
        @(posedge CLK);
        #1;
        check(REG_RDATA, WORD_ZERO);
        rd(OFS_LATCHED, ALM_FIN_TEMP);
        check({15'h0000, HEALTH_LED}, 16'h0000);
        check({15'h0000, DIGITAL_OUTPUT_TWO}, 16'h0000);
        check({15'h0000, IRQ}, 16'h0000);
        wr(OFS_IRQ_MASK, 16'h0007);
        @(posedge CLK);
        #1;
        check({15'h0000, IRQ}, 16'h0001);
        rd(OFS_IRQ_STATUS, 16'h0007);
        @(posedge CLK);
        #1;
        check({15'h0000, IRQ}, 16'h0000);
        m.apply(16'h0029, T_START);
        settle();
        rd(OFS_EARLIEST, ALM_FIN_TEMP);
        check({15'h0000, IRQ}, 16'h0001);
        rd(OFS_IRQ_STATUS, 16'h0004);
        wr(OFS_IRQ_MASK, MASK_RESET);
        m.apply(16'h0029, 13'h0000);
        settle();
        check({15'h0000, DIGITAL_OUTPUT_TWO}, 16'h0001);
        check({15'h0000, HEALTH_LED}, 16'h0000);
        m.apply(16'h0000, 13'h0000);
        settle();
        m.apply(16'h0000, T_START);
        settle();
        check({15'h0000, HEALTH_LED}, 16'h0001);
        rd(OFS_EARLIEST, WORD_ZERO);
        rd(OFS_LATCHED, ALM_FIN_TEMP);
        $display("Test first alarm and interrupt done");

        for (int i = 0; i < 16; i++) begin
            m.apply(16'h0001 << i, T_START);
            settle();
            exp_code = (i == 1 || i == 2) ? WORD_ZERO : 16'h0001 << i;
            rd(OFS_LIVE, exp_code);
            m.apply(16'h0000, T_START);
            settle();
        end
        rd(OFS_EARLIEST, ALM_OVERSPEED);
        rd(OFS_LATCHED, ALM_OVERSPEED);
        $display("Test alarm codes done");

        wr(OFS_INHIBIT, 16'hFFFF);
        m.apply(ALM_STACK_TRIP | ALM_OVERSPEED, T_START);
        settle();
        rd(OFS_LIVE, ALM_STACK_TRIP);
        m.apply(16'h0000, T_START);
        wr(OFS_INHIBIT, INHIBIT_RESET);
        m.apply(16'h0000, T_START | T_OC | T_ZS);
        settle();
        rd(OFS_LIVE, ALM_STALL);
        m.apply(16'h0000, T_START | T_OC | T_ZS | T_ZSP);
        settle();
        rd(OFS_LIVE, WORD_ZERO);
        $display("Test inhibit and stall done");

        for (int k = 0; k < 4; k++) begin
            m.apply(16'h0000, T_START | T_EN | T_DI1 | T_DI2 | T_DI4 | T_RDY | T_ZS
                    | ((k < 3) ? (T_NS << k) : 13'h0000));
            settle();
            check({15'h0000, RAMP_TO_ZERO_ACTIVE}, (k < 3) ? 16'h0001 : 16'h0000);
        end
        check({15'h0000, DRIVE_ENABLE}, 16'h0001);
        check({15'h0000, RAMP_HOLD}, 16'h0001);
        check({13'h0000, PRESET_SELECT}, 16'h0005);
        check({14'h0000, DIGITAL_OUTPUT_THREE, DIGITAL_OUTPUT_ONE}, 16'h0003);
        rd(OFS_IO_STATE, 16'h00F7);
        m.apply(16'h0000, T_START);
        settle();
        check({14'h0000, DRIVE_ENABLE, RAMP_HOLD}, 16'h0000);
        check({14'h0000, DIGITAL_OUTPUT_THREE, DIGITAL_OUTPUT_ONE}, 16'h0000);
        $display("Test terminal functions done");
        summarize();
    end
endmodule : drive_alarm_status_words_tb_top
